// [dv/digipot_two_wire_slave_control_test.sv]
// self-checking bench for the potentiometer slave with a bus master model
// assumes the master model and a pull-up on the data wire
`timescale 1ns/1ps
`default_nettype none
module digipot_two_wire_slave_control_test
  import dpt_pkg::*;
;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       shutdown_pin_n = 1'b1;
  logic [1:0] pins = 2'h0;
  logic       scl, sda_m, sda_out, sda_oe_n, sd1, sd2, lo1, lo2;
  logic       sda_out_s, sda_oe_n_s, sd1_s, sd2_s, lo1_s, lo2_s;
  logic [7:0] w1, w2, w1_s, w2_s;
  logic [7:0] ew [2];
  logic [7:0] ew_s;
  logic       ech, esd, eo1, eo2, esd_s, eo1_s, eo2_s;
  int         comparisons = 0;
  int         error_cnt = 0;
  wire        sda_bus = sda_m & (sda_oe_n | sda_out) & (sda_oe_n_s | sda_out_s);

  always #12.5 core_clk = ~core_clk;

  dpt_master_model bfm (.core_clk(core_clk), .sda_bus(sda_bus), .scl(scl), .sda_m(sda_m));
  dpt_slave #(.DUAL_CHANNEL(1'b1)) uut (
    .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_select_pin0(pins[0]), .addr_select_pin1(pins[1]),
    .shutdown_pin_n(shutdown_pin_n), .wiper_register_first(w1), .wiper_register_second(w2),
    .shutdown_first(sd1), .shutdown_second(sd2), .logic_out_first(lo1), .logic_out_second(lo2));
  // single-channel part on the same bus at the inverted address
  dpt_slave #(.DUAL_CHANNEL(1'b0)) uut_single (
    .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out_s),
    .sda_oe_n(sda_oe_n_s), .addr_select_pin0(~pins[0]), .addr_select_pin1(~pins[1]),
    .shutdown_pin_n(shutdown_pin_n), .wiper_register_first(w1_s), .wiper_register_second(w2_s),
    .shutdown_first(sd1_s), .shutdown_second(sd2_s), .logic_out_first(lo1_s), .logic_out_second(lo2_s));

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_all();
    chk("wiper1", ew[0], w1);
    chk("wiper2", ew[1], w2);
    chk("outs", {6'h0, eo2, eo1}, {6'h0, lo2, lo1});
    chk("shut", {6'h0, ~shutdown_pin_n | (esd & ech), ~shutdown_pin_n | (esd & ~ech)}, {6'h0, sd2, sd1});
    chk("single wiper1", ew_s, w1_s);
    chk("single wiper2", 8'h80, w2_s);
    chk("single outs", {6'h0, eo2_s, eo1_s}, {6'h0, lo2_s, lo1_s});
    chk("single shut", {6'h0, ~shutdown_pin_n, ~shutdown_pin_n | esd_s}, {6'h0, sd2_s, sd1_s});
  endtask
  function automatic void expect_ins(input logic [7:0] ins);
    ech = ins[7];
    esd = ins[5];
    eo2 = ins[4];
    eo1 = ins[3];
    if (ins[6]) ew[ech] = 8'h80;
  endfunction
  task automatic wr(input logic [1:0] a, input logic [7:0] ins, input logic [7:0] d, input int n);
    logic ack;
    logic hit;
    logic hit_s;
    hit = (a == pins);
    hit_s = (a == ~pins);
    bfm.start();
    bfm.send({5'h0B, a, 1'b0}, ack);
    chk("addr ack", {7'h0, ~(hit | hit_s)}, {7'h0, ack});
    bfm.send(ins, ack);
    chk("ins ack", {7'h0, ~(hit | hit_s)}, {7'h0, ack});
    if (hit) expect_ins(ins);
    if (hit_s) begin
      esd_s = ins[5];
      eo2_s = ins[4];
      eo1_s = ins[3];
      if (ins[6]) ew_s = 8'h80;
    end
    for (int k = 0; k < n; k++) begin
      bfm.send(d + 8'(k), ack);
      chk("data ack", {7'h0, ~(hit | hit_s)}, {7'h0, ack});
      if (hit) ew[ech] = d + 8'(k);
      if (hit_s) ew_s = d + 8'(k);
    end
    bfm.stop();
    chk_all();
  endtask
  task automatic rd(input logic [1:0] a, input int n);
    logic       ack;
    logic [7:0] v;
    bfm.start();
    bfm.send({5'h0B, a, 1'b1}, ack);
    chk("rd ack", 8'h0, {7'h0, ack});
    for (int k = 0; k < n; k++) begin
      bfm.recv(k == n - 1, v);
      chk("rd data", (a == pins) ? ew[ech] : ew_s, v);
    end
    bfm.stop();
  endtask
  task automatic close_out();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    error_cnt++;
    close_out();
  end

  initial begin
    logic [7:0] r;
    ew = '{8'h80, 8'h80};
    {ech, esd, eo1, eo2} = 4'h0;
    {esd_s, eo1_s, eo2_s} = 3'h0;
    ew_s = 8'h80;
    void'($urandom(20));
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    chk_all();
    $display("test reset done");
    wr(pins, 8'h87, 8'h3C, 2);
    wr(pins, 8'hC7, 8'h00, 0);
    wr(~pins, 8'hE0, 8'h21, 1);
    rd(pins, 2);
    rd(~pins, 1);
    $display("test corners done");
    for (int i = 0; i < 10; i++) begin
      r = 8'($urandom);
      @(negedge core_clk);
      pins = r[1:0];
      shutdown_pin_n = r[2];
      #1 chk_all();
      wr(pins ^ 2'($urandom_range(1, 3)), 8'($urandom), 8'h55, 1);
      wr(pins, 8'($urandom), 8'($urandom), $urandom_range(1, 3));
      rd(pins, 2);
      rd(~pins, 1);
      $display("test random pass %0d done", i);
    end
    close_out();
  end
endmodule
`default_nettype wire

// [dv/dpt_master_model.sv]
// bus master model driving scl and the master side of the open-drain sda
// assumes a pull-up on sda and calls from the bench at falling core_clk edges
`timescale 1ns/1ps
`default_nettype none
module dpt_master_model (
  input  wire logic core_clk,
  input  wire logic sda_bus,
  output logic      scl,
  output logic      sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic bit_out(input logic b);
    #50 sda_m = b;
    #50 scl = 1'b1;
    #100 scl = 1'b0;
  endtask
  task automatic bit_in(output logic b);
    #50 sda_m = 1'b1;
    #50 scl = 1'b1;
    #100 b = sda_bus;
    scl = 1'b0;
  endtask
  task automatic start();
    @(negedge core_clk);
    #50 sda_m = 1'b1;
    #50 scl = 1'b1;
    #50 sda_m = 1'b0;
    #50 scl = 1'b0;
  endtask
  task automatic stop();
    #50 sda_m = 1'b0;
    #50 scl = 1'b1;
    #50 sda_m = 1'b1;
    #50;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(ack);
  endtask
  task automatic recv(input logic mack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(mack);
  endtask
endmodule
`default_nettype wire

// [hw/dpt_pin_sync.sv]
// two-flop synchroniser with edge flags for the bus pins
// assumes pins are asynchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module dpt_pin_sync
  import dpt_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic [DPT_SYNC_STAGES-1:0] sync;
    logic                       prev;
  } dpt_sync_state_t;

  dpt_sync_state_t s_q, s_d;

  always_comb begin
    s_d      = s_q;
    s_d.sync = {s_q.sync[0], pin_in};
    s_d.prev = s_q.sync[1];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{sync: '1, prev: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.sync[1];
  assign rise  = s_q.sync[1] & ~s_q.prev;
  assign fall  = ~s_q.sync[1] & s_q.prev;
endmodule
`default_nettype wire

// [hw/dpt_slave.sv]
// two-wire slave and control logic for a one- or two-channel digital potentiometer
// assumes external pull-ups on the bus; sda_oe_n low means sda is pulled low
`timescale 1ns/1ps
`default_nettype none
module dpt_slave
  import dpt_pkg::*;
#(
  parameter bit DUAL_CHANNEL = 1'b1
)(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic       addr_select_pin0,
  input  wire logic       addr_select_pin1,
  input  wire logic       shutdown_pin_n,
  output logic [7:0]      wiper_register_first,
  output logic [7:0]      wiper_register_second,
  output logic            shutdown_first,
  output logic            shutdown_second,
  output logic            logic_out_first,
  output logic            logic_out_second
);
  typedef struct packed {
    dpt_phase_t  phase;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        ack_drive;
    logic        tx_bit;
    logic        tx_en;
    logic        rd_nack;
    logic        chan_sel;
    logic        shutdown_bit;
    logic        logic_out_first;
    logic        logic_out_second;
    logic [7:0]  wiper0;
    logic [7:0]  wiper1;
  } dpt_state_t;

  dpt_state_t s_q, s_d;
  logic scl_lvl, scl_rise, scl_fall;
  logic sda_lvl, sda_rise, sda_fall;
  logic start_ev, stop_ev;
  logic [6:0] own_addr;

  ////////////////////////////////////////////////////////////////////
  dpt_pin_sync u_scl (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (scl_in),
    .level    (scl_lvl),
    .rise     (scl_rise),
    .fall     (scl_fall)
  );

  dpt_pin_sync u_sda (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (sda_in),
    .level    (sda_lvl),
    .rise     (sda_rise),
    .fall     (sda_fall)
  );

  // single-channel parts fold the channel bit onto wiper 0
  function automatic logic eff_chan(input logic sel);
    eff_chan = DUAL_CHANNEL ? sel : 1'b0;
  endfunction

  function automatic logic [7:0] sel_wiper(input dpt_state_t st);
    sel_wiper = eff_chan(st.chan_sel) ? st.wiper1 : st.wiper0;
  endfunction

  assign own_addr = {DPT_ADDR_HI, addr_select_pin1, addr_select_pin0};
  assign start_ev = sda_fall & scl_lvl;
  assign stop_ev  = sda_rise & scl_lvl;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0] byte_in;
    logic [7:0] cur_wiper;
    byte_in = {s_q.shift[6:0], sda_lvl};
    cur_wiper = sel_wiper(s_q);
    s_d     = s_q;
    if (start_ev) begin
      s_d.phase     = DPT_ADDR;
      s_d.bit_cnt   = DPT_BIT_PRE;
      s_d.ack_drive = 1'b0;
      s_d.tx_en     = 1'b0;
    end else if (stop_ev) begin
      s_d.phase     = DPT_IDLE;
      s_d.ack_drive = 1'b0;
      s_d.tx_en     = 1'b0;
    end else if (scl_rise) begin
      case (s_q.phase)
        DPT_ADDR, DPT_INSTR, DPT_WDATA: begin
          if (s_q.bit_cnt <= DPT_BIT_LAST) begin
            s_d.shift = byte_in;
          end
        end
        DPT_RDATA: begin
          if (s_q.bit_cnt == DPT_BIT_ACK) begin
            s_d.rd_nack = sda_lvl;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      // data line changes happen just after clock falls, apart from the release at a start or stop
      s_d.ack_drive = 1'b0;
      s_d.tx_en     = 1'b0;
      s_d.bit_cnt   = s_q.bit_cnt + 4'h1;
      case (s_q.phase)
        DPT_ADDR: begin
          if (s_q.bit_cnt == DPT_BIT_LAST) begin
            if (s_q.shift[7:1] == own_addr) begin
              s_d.ack_drive = 1'b1;
            end else begin
              s_d.phase = DPT_IGNORE;
            end
          end else if (s_q.bit_cnt == DPT_BIT_ACK) begin
            s_d.bit_cnt = '0;
            if (s_q.shift[0]) begin
              s_d.phase  = DPT_RDATA;
              s_d.shift  = cur_wiper;
              s_d.tx_en  = 1'b1;
              s_d.tx_bit = cur_wiper[7];
            end else begin
              s_d.phase = DPT_INSTR;
            end
          end
        end
        DPT_INSTR, DPT_WDATA: begin
          if (s_q.bit_cnt == DPT_BIT_LAST) begin
            s_d.ack_drive = 1'b1;
          end else if (s_q.bit_cnt == DPT_BIT_ACK) begin
            s_d.bit_cnt = '0;
            s_d.phase   = DPT_WDATA;
          end
        end
        DPT_RDATA: begin
          if (s_q.bit_cnt < DPT_BIT_LAST) begin
            s_d.tx_en  = 1'b1;
            s_d.tx_bit = s_q.shift[6 - s_q.bit_cnt[2:0]];
          end else if (s_q.bit_cnt == DPT_BIT_ACK) begin
            s_d.bit_cnt = '0;
            if (!s_q.rd_nack) begin
              s_d.shift  = cur_wiper;
              s_d.tx_en  = 1'b1;
              s_d.tx_bit = cur_wiper[7];
            end else begin
              s_d.phase = DPT_IGNORE;
            end
          end
        end
        default: begin
          s_d.bit_cnt = s_q.bit_cnt;
        end
      endcase
      // apply the byte acknowledged on the ninth clock just ended
      if (s_q.bit_cnt == DPT_BIT_ACK && s_q.phase == DPT_INSTR) begin
        s_d.chan_sel         = s_q.shift[DPT_INSTR_CH_POS];
        s_d.shutdown_bit     = s_q.shift[DPT_INSTR_OFF_POS];
        s_d.logic_out_second = s_q.shift[DPT_INSTR_OUT2_POS];
        s_d.logic_out_first  = s_q.shift[DPT_INSTR_OUT1_POS];
        if (s_q.shift[DPT_INSTR_MID_POS]) begin
          if (eff_chan(s_q.shift[DPT_INSTR_CH_POS])) begin
            s_d.wiper1 = DPT_WIPER_MID;
          end else begin
            s_d.wiper0 = DPT_WIPER_MID;
          end
        end
      end
      if (s_q.bit_cnt == DPT_BIT_ACK && s_q.phase == DPT_WDATA) begin
        if (eff_chan(s_q.chan_sel)) begin
          s_d.wiper1 = s_q.shift;
        end else begin
          s_d.wiper0 = s_q.shift;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{phase: DPT_IDLE, bit_cnt: '0, shift: '0, ack_drive: 1'b0,
               tx_bit: 1'b1, tx_en: 1'b0, rd_nack: 1'b0, chan_sel: 1'b0,
               shutdown_bit: 1'b0, logic_out_first: 1'b0, logic_out_second: 1'b0,
               wiper0: DPT_WIPER_MID, wiper1: DPT_WIPER_MID};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // open drain: only ever drive low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~(s_q.ack_drive | (s_q.tx_en & ~s_q.tx_bit));

  assign wiper_register_first  = s_q.wiper0;
  assign wiper_register_second = s_q.wiper1;
  // pin path is combinational so it acts without the clock
  assign shutdown_first  = ~shutdown_pin_n | (s_q.shutdown_bit & ~eff_chan(s_q.chan_sel));
  assign shutdown_second = ~shutdown_pin_n | (s_q.shutdown_bit & eff_chan(s_q.chan_sel));
  assign logic_out_first  = s_q.logic_out_first;
  assign logic_out_second = s_q.logic_out_second;

  ////////////////////////////////////////////////////////////////////
  sequence seq_addr_ack;
    s_q.phase == DPT_ADDR && s_q.bit_cnt == DPT_BIT_LAST && scl_fall && !start_ev && !stop_ev;
  endsequence

  a_addr_ack_match: assert property (@(posedge core_clk) disable iff (rst)
    seq_addr_ack and (s_q.shift[7:1] == own_addr) |=> !sda_oe_n)
    else $error("matching address not acknowledged");

  a_nomatch_quiet: assert property (@(posedge core_clk) disable iff (rst)
    s_q.phase == DPT_IGNORE |-> sda_oe_n)
    else $error("unaddressed device drives data line");

  a_stop_idle: assert property (@(posedge core_clk) disable iff (rst)
    stop_ev && !start_ev |=> s_q.phase == DPT_IDLE && sda_oe_n)
    else $error("stop did not return to idle");

  a_start_addr: assert property (@(posedge core_clk) disable iff (rst)
    start_ev |=> s_q.phase == DPT_ADDR && s_q.bit_cnt == DPT_BIT_PRE)
    else $error("start did not open address phase");

  a_sda_hold_high: assert property (@(posedge core_clk) disable iff (rst)
    scl_lvl && !scl_fall |=> $stable(sda_oe_n))
    else $error("data line driven change while clock high");

  a_mid_reset: assert property (@(posedge core_clk) disable iff (rst)
    scl_fall && s_q.phase == DPT_INSTR && s_q.bit_cnt == DPT_BIT_ACK && s_q.shift[DPT_INSTR_MID_POS]
    && !start_ev && !stop_ev && !eff_chan(s_q.shift[DPT_INSTR_CH_POS]) |=> s_q.wiper0 == DPT_WIPER_MID)
    else $error("midscale reset not applied");

  a_wiper_load: assert property (@(posedge core_clk) disable iff (rst)
    scl_fall && s_q.phase == DPT_WDATA && s_q.bit_cnt == DPT_BIT_ACK && !start_ev && !stop_ev
    |=> sel_wiper(s_q) == $past(s_q.shift))
    else $error("data byte not loaded into wiper");

  a_shutdown_pin_n_pin: assert property (@(posedge core_clk) disable iff (rst)
    !shutdown_pin_n |-> shutdown_first && shutdown_second)
    else $error("shutdown pin not honoured");

  a_wiper_kept: assert property (@(posedge core_clk) disable iff (rst)
    !scl_fall |=> $stable(s_q.wiper0) && $stable(s_q.wiper1))
    else $error("wiper changed outside a byte end");

  // ninth fall of an instruction byte, where it takes effect
  sequence seq_instr_end;
    scl_fall && s_q.phase == DPT_INSTR && s_q.bit_cnt == DPT_BIT_ACK;
  endsequence

  // ninth fall of a byte sent in a read
  sequence seq_rd_byte_end;
    scl_fall && s_q.phase == DPT_RDATA && s_q.bit_cnt == DPT_BIT_ACK;
  endsequence

  a_instr_outs: assert property (@(posedge core_clk) disable iff (rst)
    seq_instr_end |=> logic_out_first == $past(s_q.shift[DPT_INSTR_OUT1_POS])
    && logic_out_second == $past(s_q.shift[DPT_INSTR_OUT2_POS]))
    else $error("logic outputs not latched from instruction");

  a_rd_first_bit: assert property (@(posedge core_clk) disable iff (rst)
    scl_fall && s_q.phase == DPT_ADDR && s_q.bit_cnt == DPT_BIT_ACK && s_q.shift[0]
    |=> s_q.phase == DPT_RDATA && sda_oe_n == (eff_chan(s_q.chan_sel) ? s_q.wiper1[7] : s_q.wiper0[7]))
    else $error("read did not start with wiper msb");

  a_rd_repeat: assert property (@(posedge core_clk) disable iff (rst)
    seq_rd_byte_end ##0 !s_q.rd_nack |=> s_q.phase == DPT_RDATA && s_q.shift == sel_wiper(s_q))
    else $error("acknowledged read did not reload wiper");

  a_single_fold: assert property (@(posedge core_clk) disable iff (rst)
    !DUAL_CHANNEL |-> s_q.wiper1 == DPT_WIPER_MID)
    else $error("single channel part touched second wiper");
endmodule
`default_nettype wire

// [shared/dpt_pkg.sv]
// constants and types shared by the two-wire potentiometer control slave
// assumes a single core clock; bus pins are sampled into it
package dpt_pkg;
  localparam logic [4:0] DPT_ADDR_HI        = 5'h0B;
  localparam logic [7:0] DPT_WIPER_MID      = 8'h80;
  localparam int         DPT_INSTR_CH_POS   = 7;
  localparam int         DPT_INSTR_MID_POS  = 6;
  localparam int         DPT_INSTR_OFF_POS  = 5;
  localparam int         DPT_INSTR_OUT2_POS = 4;
  localparam int         DPT_INSTR_OUT1_POS = 3;
  localparam logic [3:0] DPT_BIT_LAST       = 4'h7;
  localparam logic [3:0] DPT_BIT_ACK        = 4'h8;
  // count loaded at a start; the clock fall that closes the start wraps it to 0
  localparam logic [3:0] DPT_BIT_PRE        = 4'hF;
  localparam int         DPT_SYNC_STAGES    = 2;

  typedef enum logic [2:0] {
    DPT_IDLE,
    DPT_ADDR,
    DPT_INSTR,
    DPT_WDATA,
    DPT_RDATA,
    DPT_IGNORE
  } dpt_phase_t;
endpackage
